// File: rtl/htq_device.sv
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module htq_device (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   htq_if.dev lnk, // controller side
   output logic mac_valid, // word offered
   output logic [15:0] mac_data, // first byte in 7:0
   output logic mac_last, // last word of frame
   output logic mac_odd, // last word holds one byte
   output logic mac_crc_en, // mac appends crc
   input wire logic mac_ready // mac takes word
);
   import htq_pkg::*;
   typedef enum logic [1:0] {IN_CTRL, IN_COUNT, IN_DATA} htq_in_t;
   typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} htq_tx_t;

   // ****************
   // packet memory
   // ****************
   // dword wide, so a header is one write and padding is natural
   logic [31:0] mem_q [TX_MEM_DWORDS];
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [31:0] rd_word;
   assign rd_word = mem_q[rd_ptr_q];

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      if (p == PTR_W'(TX_MEM_DWORDS - 1)) begin
         return '0;
      end
      return p + PTR_W'(1);
   endfunction

   // ****************
   // intake
   // ****************
   htq_in_t in_st_q;
   logic [15:0] ctrl_q, lo_q, hdr_word;
   logic [BC_W-1:0] bc_in;
   logic [FREE_W-1:0] round_in, charge_in, free_q, release_amt;
   logic [PTR_W-1:0] left_q;
   logic drop_q, half_in_q, fits, hdr_wen, dat_wen, frame_in, refuse;

   assign hdr_word = lnk.big_endian ?
      {lnk.dat_word[7:0], lnk.dat_word[15:8]} : lnk.dat_word;
   assign bc_in = hdr_word[BC_W-1:0];
   assign round_in = ({2'h0, bc_in} + 13'h0003) & 13'h1FFC;
   assign charge_in = round_in + 13'h0004;
   assign fits = (bc_in != '0) && (bc_in <= BC_W'(MAX_DATA)) &&
      (charge_in <= free_q);
   assign hdr_wen = lnk.dat_wr && (in_st_q == IN_COUNT) && fits;
   assign dat_wen = lnk.dat_wr && (in_st_q == IN_DATA) && half_in_q &&
      !drop_q;
   assign frame_in = lnk.dat_wr && (in_st_q == IN_DATA) &&
      (left_q == PTR_W'(1)) && !drop_q;
   assign refuse = lnk.dat_wr && (in_st_q == IN_COUNT) && !fits;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_st_q <= IN_CTRL;
         ctrl_q <= 16'h0000;
         lo_q <= 16'h0000;
         left_q <= '0;
         drop_q <= 1'b0;
         half_in_q <= 1'b0;
      end else if (lnk.dat_wr) begin
         unique case (in_st_q)
            IN_CTRL: begin
               ctrl_q <= hdr_word;
               in_st_q <= IN_COUNT;
            end
            IN_COUNT: begin
               drop_q <= !fits;
               half_in_q <= 1'b0;
               left_q <= round_in[PTR_W:1];
               in_st_q <= (round_in == '0) ? IN_CTRL : IN_DATA;
            end
            IN_DATA: begin
               // address, length and payload are stored untouched
               lo_q <= lnk.dat_word;
               half_in_q <= !half_in_q;
               left_q <= left_q - PTR_W'(1);
               if (left_q == PTR_W'(1)) begin
                  in_st_q <= IN_CTRL;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk) begin
      if (hdr_wen) begin
         mem_q[wr_ptr_q] <= {hdr_word, ctrl_q};
      end else if (dat_wen) begin
         mem_q[wr_ptr_q] <= {lnk.dat_word, lo_q};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= '0;
      end else if (hdr_wen || dat_wen) begin
         wr_ptr_q <= bump(wr_ptr_q);
      end
   end

   // ****************
   // registers
   // ****************
   logic [1:0] tx_ctrl_q, ier_q, isr_q, isr_set, isr_clr;
   logic enq_q, ack_q, reg_hit, reg_wr, tx_done;
   logic [15:0] rdata_q, rd_mux, stat;
   logic [FID_W-1:0] fid_q;
   htq_tx_t tx_st_q;

   assign reg_hit = lnk.reg_req && !ack_q;
   assign reg_wr = reg_hit && lnk.reg_we;
   assign stat = {tx_st_q != TX_IDLE, 9'h000, fid_q};
   assign lnk.reg_ack = ack_q;
   assign lnk.reg_rdata = rdata_q;

   always_comb begin
      unique case (lnk.reg_addr)
         OFF_TX_CTRL: rd_mux = {14'h0000, tx_ctrl_q};
         OFF_TX_STAT: rd_mux = stat;
         OFF_FREE: rd_mux = {3'h0, free_q};
         OFF_QCMD: rd_mux = {15'h0000, enq_q};
         OFF_IER: rd_mux = {1'h0, ier_q, 13'h0000};
         OFF_ISR: rd_mux = {1'h0, isr_q, 13'h0000};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q <= reg_hit;
         if (reg_hit && !lnk.reg_we) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ctrl_q <= TX_CTRL_RST;
         ier_q <= 2'h0;
      end else if (reg_wr && lnk.reg_addr == OFF_TX_CTRL) begin
         tx_ctrl_q <= lnk.reg_wdata[1:0];
      end else if (reg_wr && lnk.reg_addr == OFF_IER) begin
         ier_q <= lnk.reg_wdata[ISR_TX_BIT:ISR_REFUSE_BIT];
      end
   end

   // a new enqueue wins over the clear of the frame just finished
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enq_q <= 1'b0;
      end else if (reg_wr && lnk.reg_addr == OFF_QCMD &&
            lnk.reg_wdata[QCMD_ENQ_BIT]) begin
         enq_q <= 1'b1;
      end else if (tx_done) begin
         enq_q <= 1'b0;
      end
   end

   // ****************
   // interrupts
   // ****************
   logic irq_on_q;
   assign isr_set = {tx_done && irq_on_q, refuse};
   assign isr_clr = (reg_wr && lnk.reg_addr == OFF_ISR) ?
      lnk.reg_wdata[ISR_TX_BIT:ISR_REFUSE_BIT] : 2'h0;
   assign lnk.dev_irq = |(isr_q & ier_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isr_q <= 2'h0;
      end else begin
         isr_q <= isr_set | (isr_q & ~isr_clr);
      end
   end

   // ****************
   // free space and frame count
   // ****************
   logic [BC_W-1:0] bc_q;
   logic [PTR_W-1:0] ready_cnt_q;
   logic start;
   assign release_amt = tx_done ?
      ((({2'h0, bc_q} + 13'h0003) & 13'h1FFC) + 13'h0004) : '0;
   assign start = (tx_st_q == TX_IDLE) && (ready_cnt_q != '0) && enq_q &&
      tx_ctrl_q[CTL_EN_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         free_q <= FREE_W'(TX_MEM_BYTES);
         ready_cnt_q <= '0;
      end else begin
         free_q <= free_q - (hdr_wen ? charge_in : '0) + release_amt;
         ready_cnt_q <= ready_cnt_q + PTR_W'(frame_in) -
            PTR_W'(start);
      end
   end

   // ****************
   // mac feed
   // ****************
   logic [PTR_W-1:0] out_left_q;
   logic rd_half_q, out_v_q, out_last_q, take;
   logic [15:0] out_d_q;
   assign take = !out_v_q || mac_ready;
   assign tx_done = out_v_q && mac_ready && out_last_q;
   assign mac_valid = out_v_q;
   assign mac_data = out_d_q;
   assign mac_last = out_last_q;
   assign mac_odd = out_last_q && bc_q[0];
   assign mac_crc_en = tx_ctrl_q[CTL_CRC_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q <= TX_IDLE;
         rd_ptr_q <= '0;
         rd_half_q <= 1'b0;
         out_left_q <= '0;
         out_v_q <= 1'b0;
         out_last_q <= 1'b0;
         out_d_q <= 16'h0000;
         fid_q <= '0;
         irq_on_q <= 1'b0;
         bc_q <= '0;
      end else begin
         unique case (tx_st_q)
            TX_IDLE: begin
               if (start) begin
                  tx_st_q <= TX_HDR;
               end
            end
            TX_HDR: begin
               fid_q <= rd_word[FID_W-1:0];
               irq_on_q <= rd_word[CW_IRQ_BIT];
               bc_q <= rd_word[16 +: BC_W];
               out_left_q <= PTR_W'(({1'b0, rd_word[16 +: BC_W]} +
                  12'h001) >> 1);
               rd_half_q <= 1'b0;
               rd_ptr_q <= bump(rd_ptr_q);
               tx_st_q <= TX_DATA;
            end
            TX_DATA: begin
               if (take && out_left_q != '0) begin
                  out_d_q <= rd_half_q ? rd_word[31:16] : rd_word[15:0];
                  out_v_q <= 1'b1;
                  out_last_q <= (out_left_q == PTR_W'(1));
                  out_left_q <= out_left_q - PTR_W'(1);
                  rd_half_q <= !rd_half_q;
                  if (rd_half_q) begin
                     rd_ptr_q <= bump(rd_ptr_q);
                  end
               end else if (mac_ready) begin
                  out_v_q <= 1'b0;
                  out_last_q <= 1'b0;
               end
               if (tx_done) begin
                  // skip the pad half of the final dword
                  tx_st_q <= TX_IDLE;
                  rd_half_q <= 1'b0;
                  if (rd_half_q) begin
                     rd_ptr_q <= bump(rd_ptr_q);
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: rtl/htq_host.sv
`timescale 1ns/1ns
`default_nettype none
module htq_host (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic irq, // interrupt, level
   htq_if.host lnk // device side
);
   import htq_pkg::*;

   // ****************
   // apb decode
   // ****************
   logic [11:0] dev_addr_q;
   logic [15:0] dev_wdata_q, dev_rdata_q, dat_word_q, cnt_word_q;
   logic [1:0] int_stat_q, int_mask_q;
   logic be_q, req_q, we_q, dat_wr_q, cnt_pend_q, pad_pend_q, odd_q;
   logic acc, busy, link_op, mapped, bad, go, dev_irq_d_q;
   logic [BC_W-1:0] hdr_cnt, words_in;
   logic [PTR_W-1:0] left_q;
   logic [31:0] rd_mux;

   assign acc = psel && penable;
   assign busy = req_q || cnt_pend_q || pad_pend_q;
   assign link_op = pwrite && (paddr == A_DEV_WDATA ||
      paddr == A_DEV_RDATA || paddr == A_HDR || paddr == A_DATA);
   assign pready = !(acc && link_op && busy);
   assign hdr_cnt = pwdata[HDR_CNT_LSB +: BC_W];
   assign words_in = BC_W'(({1'b0, hdr_cnt} + 12'h001) >> 1);
   assign bad = !mapped ||
      (pwrite && paddr == A_HDR && (hdr_cnt == '0 ||
      hdr_cnt > BC_W'(MAX_DATA) || left_q != '0)) ||
      (pwrite && paddr == A_DATA && left_q == '0);
   assign pslverr = acc && pready && bad;
   assign go = acc && pready && pwrite && !bad;

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         A_DEV_ADDR: rd_mux = {20'h00000, dev_addr_q};
         A_DEV_WDATA: rd_mux = {16'h0000, dev_wdata_q};
         A_DEV_RDATA: rd_mux = {16'h0000, dev_rdata_q};
         A_HDR: rd_mux = 32'h00000000;
         A_DATA: rd_mux = {21'h000000, left_q};
         A_STAT: rd_mux = {29'h00000000, be_q, lnk.dev_irq, busy};
         A_CTRL: rd_mux = {31'h00000000, be_q};
         A_INT_STAT: rd_mux = {30'h00000000, int_stat_q};
         A_INT_MASK: rd_mux = {30'h00000000, int_mask_q};
         default: begin
            rd_mux = 32'h00000000;
            mapped = 1'b0;
         end
      endcase
   end
   assign prdata = rd_mux;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_addr_q <= 12'h000;
         dev_wdata_q <= 16'h0000;
         be_q <= 1'b0;
         int_mask_q <= 2'h0;
      end else if (go) begin
         if (paddr == A_DEV_ADDR) dev_addr_q <= pwdata[11:0];
         if (paddr == A_DEV_WDATA) dev_wdata_q <= pwdata[15:0];
         if (paddr == A_CTRL) be_q <= pwdata[0];
         if (paddr == A_INT_MASK) int_mask_q <= pwdata[1:0];
      end
   end

   // ****************
   // device register access
   // ****************
   assign lnk.reg_req = req_q;
   assign lnk.reg_we = we_q;
   assign lnk.reg_addr = dev_addr_q;
   assign lnk.reg_wdata = dev_wdata_q;
   assign lnk.big_endian = be_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         we_q <= 1'b0;
         dev_rdata_q <= 16'h0000;
      end else if (req_q) begin
         if (lnk.reg_ack) begin
            req_q <= 1'b0;
            if (!we_q) dev_rdata_q <= lnk.reg_rdata;
         end
      end else if (go && paddr == A_DEV_WDATA) begin
         req_q <= 1'b1;
         we_q <= 1'b1;
      end else if (go && paddr == A_DEV_RDATA) begin
         req_q <= 1'b1;
         we_q <= 1'b0;
      end
   end

   // ****************
   // frame writer
   // ****************
   // header and pad words take a link cycle of their own, so apb
   // stalls one cycle rather than buffering
   assign lnk.dat_wr = dat_wr_q;
   assign lnk.dat_word = dat_word_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dat_wr_q <= 1'b0;
         dat_word_q <= 16'h0000;
         cnt_word_q <= 16'h0000;
         cnt_pend_q <= 1'b0;
         pad_pend_q <= 1'b0;
         left_q <= '0;
         odd_q <= 1'b0;
      end else begin
         dat_wr_q <= 1'b0;
         if (go && paddr == A_HDR) begin
            dat_wr_q <= 1'b1;
            dat_word_q <= be_q ? {pwdata[7:0], pwdata[15:8]} :
               pwdata[15:0];
            cnt_word_q <= be_q ? {hdr_cnt[7:0], 5'h00, hdr_cnt[10:8]} :
               {5'h00, hdr_cnt};
            cnt_pend_q <= 1'b1;
            left_q <= words_in;
            odd_q <= words_in[0];
         end else if (cnt_pend_q) begin
            dat_wr_q <= 1'b1;
            dat_word_q <= cnt_word_q;
            cnt_pend_q <= 1'b0;
         end else if (go && paddr == A_DATA) begin
            dat_wr_q <= 1'b1;
            dat_word_q <= pwdata[15:0];
            left_q <= left_q - PTR_W'(1);
            if (left_q == PTR_W'(1) && odd_q) begin
               pad_pend_q <= 1'b1;
            end
         end else if (pad_pend_q) begin
            dat_wr_q <= 1'b1;
            dat_word_q <= 16'h0000;
            pad_pend_q <= 1'b0;
         end
      end
   end

   // ****************
   // interrupts
   // ****************
   logic [1:0] ev, clr;
   assign ev = {lnk.dev_irq && !dev_irq_d_q, req_q && lnk.reg_ack};
   assign clr = (go && paddr == A_INT_STAT) ? pwdata[1:0] : 2'h0;
   assign irq = |(int_stat_q & int_mask_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_q <= 2'h0;
         dev_irq_d_q <= 1'b0;
      end else begin
         int_stat_q <= ev | (int_stat_q & ~clr);
         dev_irq_d_q <= lnk.dev_irq;
      end
   end
endmodule
`default_nettype wire

// File: rtl/htq_if.sv
`timescale 1ns/1ns
`default_nettype none
interface htq_if;
   logic reg_req;
   logic reg_we;
   logic [11:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_ack;
   logic [15:0] reg_rdata;
   logic dat_wr;
   logic [15:0] dat_word;
   logic big_endian;
   logic dev_irq;
   modport dev (input reg_req, reg_we, reg_addr, reg_wdata, dat_wr,
      dat_word, big_endian, output reg_ack, reg_rdata, dev_irq);
   modport host (output reg_req, reg_we, reg_addr, reg_wdata, dat_wr,
      dat_word, big_endian, input reg_ack, reg_rdata, dev_irq);
endinterface
`default_nettype wire

// File: rtl/htq_pkg.sv
package htq_pkg;
   // ****************
   // device side
   // ****************
   localparam int RX_MEM_BYTES = 12288;
   localparam int TX_MEM_BYTES = 6144;
   localparam int TX_MEM_DWORDS = TX_MEM_BYTES / 4;
   localparam int PTR_W = 11;
   localparam int MAX_DATA = 2000;
   localparam int FID_W = 6;
   localparam int BC_W = 11;
   localparam int FREE_W = 13;
   localparam int CW_IRQ_BIT = 15;
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_CRC_BIT = 1;
   localparam int QCMD_ENQ_BIT = 0;
   localparam int ISR_TX_BIT = 14;
   localparam int ISR_REFUSE_BIT = 13;
   localparam int STAT_BUSY_BIT = 15;
   localparam logic [11:0] OFF_TX_CTRL = 12'h170;
   localparam logic [11:0] OFF_TX_STAT = 12'h172;
   localparam logic [11:0] OFF_FREE = 12'h178;
   localparam logic [11:0] OFF_QCMD = 12'h180;
   localparam logic [11:0] OFF_IER = 12'h190;
   localparam logic [11:0] OFF_ISR = 12'h192;
   localparam logic [1:0] TX_CTRL_RST = 2'h0;
   // ****************
   // controller side
   // ****************
   localparam logic [7:0] A_DEV_ADDR = 8'h00;
   localparam logic [7:0] A_DEV_WDATA = 8'h04;
   localparam logic [7:0] A_DEV_RDATA = 8'h08;
   localparam logic [7:0] A_HDR = 8'h0C;
   localparam logic [7:0] A_DATA = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_CTRL = 8'h18;
   localparam logic [7:0] A_INT_STAT = 8'h1C;
   localparam logic [7:0] A_INT_MASK = 8'h20;
   localparam int HDR_CNT_LSB = 16;
   localparam int HI_OP_DONE = 0;
   localparam int HI_DEV_IRQ = 1;
endpackage

// File: verification/host_tx_queue_frame_intake_test.sv
`timescale 1ns/1ns
`default_nettype none
module host_tx_queue_frame_intake_test;
   import htq_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, mac_valid, mac_last, mac_odd, mac_crc_en;
   logic [15:0] mac_data;
   logic mac_ready = 1'b0;
   logic stall = 1'b1;
   int fails = 0;
   int comparisons = 0;
   int lasts = 0;
   logic [7:0] rx_q[$];
   logic [31:0] rd;
   logic err;
   htq_if lnk ();
   htq_host htq_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .lnk(lnk.host));
   htq_device htq_device_inst (.pclk(pclk), .presetn(presetn),
      .lnk(lnk.dev), .mac_valid(mac_valid), .mac_data(mac_data),
      .mac_last(mac_last), .mac_odd(mac_odd), .mac_crc_en(mac_crc_en),
      .mac_ready(mac_ready));
   htq_asserts htq_asserts_inst (.pclk(pclk), .presetn(presetn),
      .reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
      .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
      .dat_wr(lnk.dat_wr), .dat_word(lnk.dat_word),
      .big_endian(lnk.big_endian));
   always #5 pclk = ~pclk;
   // mac side takes a word every other cycle unless stalled
   always @(posedge pclk) begin
      if (mac_valid && mac_ready) begin
         rx_q.push_back(mac_data[7:0]);
         if (!(mac_last && mac_odd)) rx_q.push_back(mac_data[15:8]);
         if (mac_last) lasts++;
      end
      mac_ready <= !stall && !mac_ready;
   end
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // read data and error are taken at the edge that sees pready high;
   // hangs are left to the watchdog
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic dev_op(input logic [11:0] off, input logic w,
      input logic [15:0] d);
      apb(1'b1, A_INT_STAT, 32'h1);
      apb(1'b1, A_DEV_ADDR, {20'h0, off});
      apb(1'b1, w ? A_DEV_WDATA : A_DEV_RDATA, {16'h0, d});
      do apb(1'b0, A_INT_STAT, 32'h0);
      while (rd[HI_OP_DONE] !== 1'b1);
      apb(1'b0, A_DEV_RDATA, 32'h0);
   endtask
   task automatic dev_chk(input logic [11:0] off, input logic [15:0] exp);
      dev_op(off, 1'b0, 16'h0);
      chk({16'h0, rd[15:0]}, {16'h0, exp});
   endtask
   function automatic logic [7:0] pat(input logic [15:0] c, input int i);
      return 8'(c[5:0] * 3 + i * 7);
   endfunction
   task automatic put_frame(input logic [15:0] c, input int cnt);
      apb(1'b1, A_HDR, {5'h0, cnt[10:0], c});
      apb(1'b0, A_DATA, 32'h0);
      chk(rd, 32'((cnt + 1) / 2));
      for (int i = 0; i < (cnt + 1) / 2; i++) begin
         apb(1'b1, A_DATA, {16'h0, pat(c, 2 * i + 1), pat(c, 2 * i)});
      end
   endtask
   task automatic send_frame(input logic [15:0] c, input int cnt,
      input logic [15:0] isr);
      rx_q.delete();
      stall <= 1'b1;
      dev_op(OFF_QCMD, 1'b1, 16'h0001);
      dev_chk(OFF_TX_STAT, {10'h200, c[5:0]});
      stall <= 1'b0;
      do dev_op(OFF_QCMD, 1'b0, 16'h0);
      while (rd[0] !== 1'b0);
      chk(rd[0], 32'h0);
      chk(rx_q.size(), cnt);
      for (int i = 0; i < cnt; i++) chk(rx_q[i], pat(c, i));
      dev_chk(OFF_ISR, isr);
   endtask
   // ****************
   // scenarios
   // ****************
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      dev_chk(OFF_FREE, 16'(TX_MEM_BYTES));
      dev_chk(OFF_TX_CTRL, 16'h0000);
      dev_chk(OFF_TX_STAT, 16'h0000);
      apb(1'b0, 8'h24, 32'h0);
      chk(err, 32'h1);
      apb(1'b1, A_DATA, 32'h0);
      chk(err, 32'h1);
      apb(1'b1, A_HDR, 32'h0000_0001);
      chk(err, 32'h1);
      apb(1'b1, A_HDR, {5'h0, 11'h7D1, 16'h0001});
      chk(err, 32'h1);
      dev_op(OFF_TX_CTRL, 1'b1, 16'h0003);
      chk(mac_crc_en, 32'h1);
      dev_op(OFF_IER, 1'b1, 16'h6000);
      apb(1'b1, A_INT_MASK, 32'h2);
      put_frame(16'h8005, 13);
      dev_chk(OFF_FREE, 16'h17EC);
      put_frame(16'h002A, 2000);
      dev_chk(OFF_FREE, 16'h1018);
      send_frame(16'h8005, 13, 16'h4000);
      chk(irq, 32'h1);
      apb(1'b1, A_INT_MASK, 32'h0);
      chk(irq, 32'h0);
      dev_op(OFF_ISR, 1'b1, 16'h4000);
      apb(1'b1, A_INT_STAT, 32'h2);
      apb(1'b1, A_INT_MASK, 32'h2);
      chk(irq, 32'h0);
      dev_chk(OFF_FREE, 16'h102C);
      send_frame(16'h002A, 2000, 16'h0000);
      apb(1'b1, A_CTRL, 32'h1);
      put_frame(16'h8011, 4);
      send_frame(16'h8011, 4, 16'h4000);
      dev_op(OFF_ISR, 1'b1, 16'h4000);
      apb(1'b1, A_CTRL, 32'h0);
      for (int i = 1; i <= 4; i++) put_frame(16'(i), 2000);
      dev_chk(OFF_FREE, 16'h0084);
      dev_chk(OFF_ISR, 16'h2000);
      dev_op(OFF_ISR, 1'b1, 16'h2000);
      for (int i = 1; i <= 3; i++) send_frame(16'(i), 2000, 16'h0);
      chk(lasts, 32'h6);
      dev_chk(OFF_FREE, 16'(TX_MEM_BYTES));
      final_report();
   end
   initial begin
      #900000;
      fails++;
      final_report();
   end
endmodule
`default_nettype wire

// File: verification/htq_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module htq_asserts (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic reg_req, // register request
   input wire logic reg_we, // register direction
   input wire logic [11:0] reg_addr, // device offset
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_ack, // register answer
   input wire logic dat_wr, // memory word strobe
   input wire logic [15:0] dat_word, // memory word
   input wire logic big_endian // header byte order
);
   logic [1:0] ph_q;
   logic [10:0] left_q;
   logic [15:0] sw;
   logic [11:0] cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign sw = big_endian ? {dat_word[7:0], dat_word[15:8]} : dat_word;
   assign cnt = {1'b0, sw[10:0]};
   // ****************
   // frame phase: control, count, padded data words
   // ****************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= 2'h0;
         left_q <= 11'h0;
      end else if (dat_wr) begin
         case (ph_q)
            2'h0: ph_q <= 2'h1;
            2'h1: begin
               ph_q <= 2'h2;
               left_q <= 11'(((cnt + 12'h3) >> 2) << 1);
            end
            default: begin
               left_q <= left_q - 11'h1;
               if (left_q == 11'h1) ph_q <= 2'h0;
            end
         endcase
      end
   end
   property p_ack_follows_req;
      $rose(reg_req) |=> reg_ack;
   endproperty
   a_ack_follows_req: assert property (p_ack_follows_req)
      else $error("register answer not one cycle after request");
   property p_ack_single;
      reg_ack |=> !reg_ack;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("register answer wider than one cycle");
   property p_ack_needs_req;
      reg_ack |-> reg_req;
   endproperty
   a_ack_needs_req: assert property (p_ack_needs_req)
      else $error("register answer without request");
   property p_req_drops;
      reg_ack |=> !reg_req;
   endproperty
   a_req_drops: assert property (p_req_drops)
      else $error("request held after answer");
   property p_req_holds;
      reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
         && $stable(reg_we) && $stable(reg_wdata);
   endproperty
   a_req_holds: assert property (p_req_holds)
      else $error("request changed before answer");
   property p_count_follows_ctrl;
      dat_wr && ph_q == 2'h0 |=> dat_wr;
   endproperty
   a_count_follows_ctrl: assert property (p_count_follows_ctrl)
      else $error("count word not right after control word");
   property p_count_range;
      dat_wr && ph_q == 2'h1 |-> cnt != 12'h0 && cnt <= 12'h7D0;
   endproperty
   a_count_range: assert property (p_count_range)
      else $error("byte count zero or too large");
   property p_count_reserved;
      dat_wr && ph_q == 2'h1 |-> sw[15:11] == 5'h00;
   endproperty
   a_count_reserved: assert property (p_count_reserved)
      else $error("count word reserved bits set");
   property p_link_exclusive;
      reg_req |-> !dat_wr;
   endproperty
   a_link_exclusive: assert property (p_link_exclusive)
      else $error("memory word during register op");
endmodule
`default_nettype wire
